//--- core/pin_io_ctrl.sv
`timescale 1ns/1ps
`include "pin_io_regs.svh"
// Functional notes
// - serial output bits change on the falling serial clock edge.
// - serial output is high impedance while chip select is high.
// - dual read drives lanes 1 and 0, two bits per falling edge.
// - write-protect input is active low and blocks status register writes only while lock bit 0 is set.
// - write-protect with guard, region and lock bits protects array portions.
// - quad lane enable set disables write-protect; pin becomes lane 2.
// - while paused, clock and input ignored and output high impedance.
// - pause stops serial traffic only; internal cycles continue, no reset.
// - quad program: pause pin is lane 3 input, four bits per rising edge.
// - quad read: pause pin is lane 3 output, four bits per falling edge.
// - commands, addresses and input data latch on rising clock edge.
// - select high deselects and tri-states outputs; select low enables.
module pin_io_ctrl
  import pin_io_pkg::*;
(
  input  wire logic                  CLK,
  input  wire logic                  RST,
  input  wire logic                  CS_N,
  input  wire logic                  SCK,
  input  wire logic                  SI_IN,
  output      logic                  SI_OUT,
  output      logic                  SI_OE_N,
  input  wire logic                  SO_IN,
  output      logic                  SO_OUT,
  output      logic                  SO_OE_N,
  input  wire logic                  WP_N_IN,
  output      logic                  WP_N_OUT,
  output      logic                  WP_N_OE_N,
  input  wire logic                  HOLD_N_IN,
  output      logic                  HOLD_N_OUT,
  output      logic                  HOLD_N_OE_N,
  input  wire logic                  QUAD_LANE_ENABLE_BIT,
  input  wire logic                  REGION_GUARD_BIT0,
  input  wire logic                  REGION_GUARD_BIT1,
  input  wire logic                  REGION_GUARD_BIT2,
  input  wire logic                  TOP_BOTTOM_SELECT,
  input  wire logic                  SMALL_REGION_SELECT,
  input  wire logic [1:0]            STATUS_LOCK_BITS,
  input  wire pin_io_pkg::lane_mode_t IN_MODE,
  input  wire pin_io_pkg::lane_mode_t OUT_MODE,
  input  wire logic                  OUT_PHASE,
  input  wire logic [7:0]            TX_BYTE,
  output      logic                  TX_TAKE,
  output      logic [7:0]            RX_BYTE,
  output      logic                  RX_VALID,
  output      logic [`BITCNT_W-1:0]  BIT_POS,
  output      logic                  PAUSED,
  output      logic                  SELECTED,
  input  wire logic                  STATUS_WR_REQ,
  output      logic                  STATUS_WR_OK,
  output      logic [`PROT_W-1:0]    HW_PROT_WORD,
  output      logic                  HW_PROT_ACTIVE,
  input  wire logic                  INTERNAL_BUSY,
  output      logic                  INTERNAL_BUSY_SEEN
);
  import pin_io_pkg::*;

  pin_sync_if sy ();

  logic hold_s1_r, hold_s2_r, wp_s1_r, wp_s2_r;

  // lane 3 in quad mode is data, so it goes through the common syncer too
  pin_sync u_sync (
    .clk      (CLK),
    .rst      (RST),
    .cs_n_pin (CS_N),
    .sck_pin  (SCK),
    .lane_pin ({HOLD_N_IN, WP_N_IN, SO_IN, SI_IN}),
    .sy       (sy)
  );

  // control-role levels of the pause and protect pins
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      hold_s1_r <= 1'b1;
      hold_s2_r <= 1'b1;
      wp_s1_r   <= 1'b1;
      wp_s2_r   <= 1'b1;
    end else begin
      hold_s1_r <= HOLD_N_IN;
      hold_s2_r <= hold_s1_r;
      wp_s1_r   <= WP_N_IN;
      wp_s2_r   <= wp_s1_r;
    end
  end

  link_state_t          st_r, st_nxt;
  logic [7:0]           rx_sh_r, rx_sh_nxt;
  logic [7:0]           tx_sh_r, tx_sh_nxt;
  logic [3:0]           dout_r, dout_nxt;
  logic [`BITCNT_W-1:0] cnt_r, cnt_nxt;
  logic                 rxv_r, rxv_nxt;
  logic                 take_r, take_nxt;
  logic                 drive_r, drive_nxt;
  logic                 quad_pins;
  logic                 hold_act;
  logic                 sel;
  logic [3:0]           step;

  // pause only exists while the pin is not a quad data lane
  assign quad_pins = QUAD_LANE_ENABLE_BIT;
  assign sel       = ~sy.sel_n;
  assign hold_act  = ~hold_s2_r & ~quad_pins;

  // next state: pause entry is only honoured with clock low and select low
  always_comb begin
    st_nxt    = st_r;
    rx_sh_nxt = rx_sh_r;
    tx_sh_nxt = tx_sh_r;
    dout_nxt  = dout_r;
    cnt_nxt   = cnt_r;
    rxv_nxt   = 1'b0;
    take_nxt  = 1'b0;
    drive_nxt = drive_r;
    step      = 4'h1;
    case (st_r)
      ST_IDLE: begin
        drive_nxt = 1'b0;
        cnt_nxt   = '0;
        if (sel) begin
          st_nxt    = ST_ACTIVE;
          tx_sh_nxt = TX_BYTE;
          take_nxt  = 1'b1;
        end
      end
      ST_ACTIVE: begin
        if (!sel) begin
          st_nxt = ST_IDLE;
        end else if (hold_act && !sy.sck_lvl) begin
          st_nxt = ST_PAUSED;
        end else begin
          if (sy.sck_rise && !OUT_PHASE) begin
            case (IN_MODE)
              LANE_DUAL: begin
                rx_sh_nxt = {rx_sh_r[5:0], sy.lane_in[1:0]};
                step      = 4'h2;
              end
              LANE_QUAD: begin
                rx_sh_nxt = {rx_sh_r[3:0], sy.lane_in};
                step      = 4'h4;
              end
              default: begin
                rx_sh_nxt = {rx_sh_r[6:0], sy.lane_in[0]};
                step      = 4'h1;
              end
            endcase
            cnt_nxt = cnt_r + `BITCNT_W'(step);
            if (cnt_r[2:0] + 3'(step) == 3'h0) begin
              rxv_nxt = 1'b1;
            end
          end
          if (sy.sck_fall && OUT_PHASE) begin
            drive_nxt = 1'b1;
            case (OUT_MODE)
              LANE_DUAL: begin
                dout_nxt  = {2'b00, tx_sh_r[7:6]};
                tx_sh_nxt = {tx_sh_r[5:0], 2'b00};
                step      = 4'h2;
              end
              LANE_QUAD: begin
                dout_nxt  = tx_sh_r[7:4];
                tx_sh_nxt = {tx_sh_r[3:0], 4'h0};
                step      = 4'h4;
              end
              default: begin
                dout_nxt  = {2'b00, tx_sh_r[7], 1'b0};
                tx_sh_nxt = {tx_sh_r[6:0], 1'b0};
                step      = 4'h1;
              end
            endcase
            cnt_nxt = cnt_r + `BITCNT_W'(step);
            if (cnt_r[2:0] + 3'(step) == 3'h0) begin
              tx_sh_nxt = TX_BYTE;
              take_nxt  = 1'b1;
            end
          end
        end
      end
      ST_PAUSED: begin
        // counters and shifters frozen so release resumes in place
        if (!sel) begin
          st_nxt = ST_IDLE;
        end else if (!hold_act) begin
          st_nxt = ST_ACTIVE;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_r    <= ST_IDLE;
      rx_sh_r <= 8'h00;
      tx_sh_r <= 8'h00;
      dout_r  <= 4'h0;
      cnt_r   <= '0;
      rxv_r   <= 1'b0;
      take_r  <= 1'b0;
      drive_r <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      rx_sh_r <= rx_sh_nxt;
      tx_sh_r <= tx_sh_nxt;
      dout_r  <= dout_nxt;
      cnt_r   <= cnt_nxt;
      rxv_r   <= rxv_nxt;
      take_r  <= take_nxt;
      drive_r <= drive_nxt;
    end
  end

  logic out_en;
  // outputs released when deselected or paused
  assign out_en = drive_r & OUT_PHASE & (st_r == ST_ACTIVE) & sel;

  // pin drive; oe low means driving
  always_comb begin
    SI_OE_N     = 1'b1;
    SO_OE_N     = 1'b1;
    WP_N_OE_N   = 1'b1;
    HOLD_N_OE_N = 1'b1;
    if (out_en) begin
      case (OUT_MODE)
        LANE_DUAL: begin
          SI_OE_N = 1'b0;
          SO_OE_N = 1'b0;
        end
        LANE_QUAD: begin
          SI_OE_N     = 1'b0;
          SO_OE_N     = 1'b0;
          WP_N_OE_N   = ~quad_pins;
          HOLD_N_OE_N = ~quad_pins;
        end
        default: SO_OE_N = 1'b0;
      endcase
    end
  end

  assign SI_OUT     = dout_r[0];
  assign SO_OUT     = dout_r[1];                                   // lane 1 in every mode
  assign WP_N_OUT   = dout_r[2];
  assign HOLD_N_OUT = dout_r[3];
  assign RX_BYTE    = rx_sh_r;
  assign RX_VALID   = rxv_r;
  assign TX_TAKE    = take_r;
  assign BIT_POS    = cnt_r;
  assign PAUSED     = (st_r == ST_PAUSED);
  assign SELECTED   = sel;

  // protection: pin active only when not repurposed as a lane
  logic wp_asserted;
  assign wp_asserted    = ~wp_s2_r & ~quad_pins;
  assign STATUS_WR_OK   = STATUS_WR_REQ & ~(wp_asserted & STATUS_LOCK_BITS[0]);
  assign HW_PROT_WORD   = {STATUS_LOCK_BITS, SMALL_REGION_SELECT, TOP_BOTTOM_SELECT,
                           REGION_GUARD_BIT2, REGION_GUARD_BIT1, REGION_GUARD_BIT0};
  assign HW_PROT_ACTIVE = wp_asserted & STATUS_LOCK_BITS[0]
                        & (REGION_GUARD_BIT0 | REGION_GUARD_BIT1 | REGION_GUARD_BIT2);
  // internal cycles are not touched by pause; just reported through
  assign INTERNAL_BUSY_SEEN = INTERNAL_BUSY;
endmodule

//--- core/pin_io_pkg.sv
package pin_io_pkg;
  // lane width of the current transfer phase
  typedef enum logic [1:0] {
    LANE_SINGLE = 2'b00,
    LANE_DUAL   = 2'b01,
    LANE_QUAD   = 2'b10
  } lane_mode_t;
  // serial engine state
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_ACTIVE = 2'b01,
    ST_PAUSED = 2'b10
  } link_state_t;
endpackage

//--- core/pin_io_regs.svh
`ifndef PIN_IO_REGS_SVH
`define PIN_IO_REGS_SVH
// lane widths and counter sizes
`define LANES            4
`define BITCNT_W         6
// protection bit positions inside the protection word
`define PROT_GUARD0_BIT  0
`define PROT_GUARD1_BIT  1
`define PROT_GUARD2_BIT  2
`define PROT_TB_BIT      3
`define PROT_SMALL_BIT   4
`define PROT_LOCK0_BIT   5
`define PROT_LOCK1_BIT   6
`define PROT_W           7
`endif

//--- core/pin_sync.sv
`timescale 1ns/1ps
`include "pin_io_regs.svh"
// two-stage synchronisers for the pins plus serial clock edge detect
module pin_sync (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       cs_n_pin,
  input  wire logic       sck_pin,
  input  wire logic [3:0] lane_pin,
  pin_sync_if.src         sy
);
  logic [5:0] s1_r, s1_nxt;
  logic [5:0] s2_r, s2_nxt;
  logic       sck_d_r, sck_d_nxt;

  // first stage is read only by the second stage
  always_comb begin
    s1_nxt    = {cs_n_pin, sck_pin, lane_pin};
    s2_nxt    = s1_r;
    sck_d_nxt = s2_r[4];
  end

  // select resets to deselected and clock to its low idle level, so no false edge follows reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_r    <= 6'h20;
      s2_r    <= 6'h20;
      sck_d_r <= 1'b0;
    end else begin
      s1_r    <= s1_nxt;
      s2_r    <= s2_nxt;
      sck_d_r <= sck_d_nxt;
    end
  end

  assign sy.sel_n    = s2_r[5];
  assign sy.sck_lvl  = s2_r[4];
  assign sy.lane_in  = s2_r[3:0];
  assign sy.sck_rise = s2_r[4] & ~sck_d_r;
  assign sy.sck_fall = ~s2_r[4] & sck_d_r;
endmodule

//--- core/pin_sync_if.sv
`timescale 1ns/1ps
// synchronised pin levels and clock edge pulses passed to the engine
interface pin_sync_if;
  logic       sel_n;
  logic       sck_rise;
  logic       sck_fall;
  logic       sck_lvl;
  logic [3:0] lane_in;
  modport src (output sel_n, sck_rise, sck_fall, sck_lvl, lane_in);
  modport dst (input sel_n, sck_rise, sck_fall, sck_lvl, lane_in);
endinterface

//--- tb/pin_io_ctrl_monitor.sv
`timescale 1ns/1ps
// port-level watch of the pin block
module pin_io_ctrl_monitor (
  input wire logic       CLK,
  input wire logic       RST,
  input wire logic       SCK,
  input wire logic       SO_OUT,
  input wire logic       SI_OE_N,
  input wire logic       SO_OE_N,
  input wire logic       WP_N_OE_N,
  input wire logic       HOLD_N_OE_N,
  input wire logic       SELECTED,
  input wire logic       PAUSED,
  input wire logic [5:0] BIT_POS,
  input wire logic       INTERNAL_BUSY,
  input wire logic       INTERNAL_BUSY_SEEN,
  input wire logic       STATUS_WR_REQ,
  input wire logic       STATUS_WR_OK,
  input wire logic       WP_N_IN,
  input wire logic       QUAD_LANE_ENABLE_BIT,
  input wire logic [1:0] STATUS_LOCK_BITS
);
  logic all_off;
  // high when no lane is driven by the block
  assign all_off = SI_OE_N & SO_OE_N & WP_N_OE_N & HOLD_N_OE_N;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  a_idle_release: assert property (!SELECTED && !$past(SELECTED) |-> all_off)
    else $error("lane driven while idle");
  a_pause_release: assert property (PAUSED |-> all_off)
    else $error("lane driven in pause");
  a_pause_selected: assert property ($rose(PAUSED) |-> $past(SELECTED))
    else $error("pause entered while deselected");
  a_pause_freeze: assert property (PAUSED ##1 PAUSED |-> $stable(BIT_POS))
    else $error("position moved in pause");
  a_busy_through: assert property (INTERNAL_BUSY_SEEN == INTERNAL_BUSY)
    else $error("busy disturbed");
  // the protect pin reaches the write gate through two flops
  a_wp_blocks: assert property (!$past(WP_N_IN, 2) && !QUAD_LANE_ENABLE_BIT && STATUS_LOCK_BITS[0]
    |-> !STATUS_WR_OK)
    else $error("protected write passed");
  a_quad_frees_wp: assert property (STATUS_WR_REQ && QUAD_LANE_ENABLE_BIT |-> STATUS_WR_OK)
    else $error("quad kept protect");
  a_quad_no_pause: assert property ($rose(PAUSED) |-> !QUAD_LANE_ENABLE_BIT)
    else $error("pause in quad mode");
  // two sync flops and the output flop put the pin fall three to four samples back
  a_fall_shift: assert property (SELECTED && $past(SELECTED) && $changed(SO_OUT) |-> $past(SCK, 4) && !$past(SCK, 3))
    else $error("output moved off a fall");
endmodule
bind pin_io_ctrl pin_io_ctrl_monitor mon_u (.*);

//--- tb/spi_host_model.sv
`timescale 1ns/1ps
// host end of the link; its clock rests low outside frames
module spi_host_model (
  input  wire logic       clk,
  input  wire logic [3:0] dev_out,
  input  wire logic [3:0] dev_oe_n,
  output      logic       cs_n,
  output      logic       sck,
  output      logic [3:0] lane
);
  logic [3:0] drv = 4'hc;
  logic [3:0] own = 4'hc;
  logic       tog = 1'b0;
  // no pull-ups: a released lane wanders rather than keeping a value
  always @(posedge clk)
    tog <= ~tog;
  always_comb
    for (int i = 0; i < 4; i++)
      lane[i] = !dev_oe_n[i] ? dev_out[i] : own[i] ? drv[i] : tog;
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
  end
  // one byte, w lanes per edge, msb first; a read releases the output lanes
  task automatic xfer(input logic [7:0] tx, input int w, input bit rd, input int hold_at, output logic [7:0] rx);
    logic [3:0] m;
    logic [7:0] sh;
    m = (w == 4) ? 4'hf : (w == 2) ? 4'h3 : (rd ? 4'h2 : 4'h1);
    own = rd ? ~m : 4'hf;
    rx = 8'h00;
    #2 cs_n = 1'b0; // off the block's clock edge
    #250;
    for (int e = 0; e < 8 / w; e++) begin
      sh = tx << (e * w);
      if (!rd)
        drv = (w == 4) ? sh[7:4] : (w == 2) ? {2'b11, sh[7:6]} : {3'b110, sh[7]};
      if (e == hold_at) begin
        drv[3] = 1'b0; // select low and clock low here
        #100 sck = 1'b1;
        #100 sck = 1'b0;
        #100 drv[3] = 1'b1;
        #100;
      end
      #6.5 sck = 1'b1;
      #62.5 sck = 1'b0;
      #56 rx = (rx << w) | ((w == 1) ? 8'(lane[1]) : 8'(lane & m));
    end
    #62.5 cs_n = 1'b1;
    drv = 4'hc;
    own = 4'hc;
    #250;
  endtask
endmodule

//--- tb/test_flash_serial_pin_io_control.sv
`timescale 1ns/1ps
module test_flash_serial_pin_io_control;
  import pin_io_pkg::*;
  logic       CLK = 1'b0, RST = 1'b1, CS_N, SCK, OUT_PHASE = 1'b0, STATUS_WR_REQ = 1'b0, INTERNAL_BUSY = 1'b0;
  logic       QUAD_LANE_ENABLE_BIT = 1'b0, REGION_GUARD_BIT0 = 1'b0, REGION_GUARD_BIT1 = 1'b0;
  logic       REGION_GUARD_BIT2 = 1'b0, TOP_BOTTOM_SELECT = 1'b0, SMALL_REGION_SELECT = 1'b0;
  logic [1:0] STATUS_LOCK_BITS = 2'h0;
  logic [7:0] TX_BYTE = 8'h00, RX_BYTE;
  logic [6:0] HW_PROT_WORD, prot;
  logic [5:0] BIT_POS;
  logic [3:0] lane;
  lane_mode_t IN_MODE = LANE_SINGLE, OUT_MODE = LANE_SINGLE;
  logic       SI_OUT, SI_OE_N, SO_OUT, SO_OE_N, WP_N_OUT, WP_N_OE_N, HOLD_N_OUT, HOLD_N_OE_N, TX_TAKE;
  logic       RX_VALID, PAUSED, SELECTED, STATUS_WR_OK, HW_PROT_ACTIVE, INTERNAL_BUSY_SEEN;
  wire        SI_IN = lane[0], SO_IN = lane[1], WP_N_IN = lane[2], HOLD_N_IN = lane[3];
  int         seed = 36, err_count = 0, num_checks = 0, npause = 0, ntake = 0;
  logic [7:0] rx_q[$];
  pin_io_ctrl dut_u (.*);
  spi_host_model host_u (
    .clk      (CLK),
    .dev_out  ({HOLD_N_OUT, WP_N_OUT, SO_OUT, SI_OUT}),
    .dev_oe_n ({HOLD_N_OE_N, WP_N_OE_N, SO_OE_N, SI_OE_N}),
    .cs_n     (CS_N),
    .sck      (SCK),
    .lane     (lane)
  );
  always #5 CLK = ~CLK;
  // received bytes queue up; pause cycles are counted
  always @(posedge CLK) begin
    if (RX_VALID === 1'b1)
      rx_q.push_back(RX_BYTE);
    if (PAUSED === 1'b1)
      npause++;
    if (TX_TAKE === 1'b1)
      ntake++;
  end
  task automatic chk(input bit ok, input string msg);
    num_checks++;
    if (!ok) begin
      err_count++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // one random byte each way; the expected value is the byte itself
  task automatic run(input int m, input bit rd, input int hold_at);
    logic [7:0] b, got;
    b = 8'($random(seed));
    @(posedge CLK);
    TX_BYTE <= b;
    IN_MODE <= lane_mode_t'(m);
    OUT_MODE <= lane_mode_t'(m);
    OUT_PHASE <= rd;
    QUAD_LANE_ENABLE_BIT <= (m == 2);
    rx_q.delete();
    ntake = 0;
    host_u.xfer(b, 1 << m, rd, hold_at, got);
    // one load at select, one more at the byte boundary of a read
    chk(ntake == (rd ? 2 : 1), "byte load count");
    if (!rd)
      got = (rx_q.size() > 0) ? rx_q.pop_front() : 8'hxx;
    chk(got === b, "byte mismatch");
    chk({HOLD_N_OE_N, WP_N_OE_N, SO_OE_N, SI_OE_N} === 4'hf, "lanes held after deselect");
  endtask
  initial begin
    repeat (8) @(posedge CLK);
    RST <= 1'b0;
    repeat (4) @(posedge CLK);
    for (int m = 0; m < 3; m++)
      for (int rd = 0; rd < 2; rd++)
        run(m, rd[0], -1);
    INTERNAL_BUSY <= 1'b1;
    run(0, 1'b1, 3);
    run(0, 1'b0, 5);
    INTERNAL_BUSY <= 1'b0;
    chk(npause > 0, "pause never taken");
    // protect pin against quad lane and lock bit, random region bits
    for (int k = 0; k < 8; k++) begin
      prot = 7'($random(seed));
      prot[5] = k[2];
      @(posedge CLK);
      host_u.drv[2] <= k[0];
      QUAD_LANE_ENABLE_BIT <= k[1];
      STATUS_WR_REQ <= 1'b1;
      {STATUS_LOCK_BITS, SMALL_REGION_SELECT, TOP_BOTTOM_SELECT} <= prot[6:3];
      {REGION_GUARD_BIT2, REGION_GUARD_BIT1, REGION_GUARD_BIT0} <= prot[2:0];
      // the protect pin needs two flops plus one edge to settle at the gate
      repeat (3) @(posedge CLK);
      chk(STATUS_WR_OK === !(!k[0] && !k[1] && k[2]), "status write gate");
      chk(HW_PROT_WORD === prot, "protection word");
      chk(HW_PROT_ACTIVE === (!k[0] && !k[1] && k[2] && prot[2:0] != 3'h0), "hardware protect flag");
    end
    print_verdict;
  end
  // cut a hang short
  initial begin
    #200us;
    err_count++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    print_verdict;
  end
endmodule
